// *** sec_decoder.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Reset clears programming logic and leaves writes disabled.
// R2 - Host keeps select low while supply ramps.
// R3 - Instruction opens on select rising with clock low, then awaits start.
// R4 - Start bit is first one sampled on data-in at clock rise.
// R5 - Two bits after start are opcode; top address bits may extend it.
// R6 - Address field is 6 or 8 bits by density.
// R7 - Middle density ignores the address MSB.
// R8 - Fully static; any serial clock rate down to stopped.
// R9 - Word write: opcode 01, PRE low, W high, skipped if protected.
// R10 - Page write: opcode 11, skipped if any addressed word protected.
// R11 - Opcode 00 extensions: enable/unlock, disable, fill-all.
// R12 - Opcode 10 with PRE high reads boundary then flag.
// R13 - All-zero address freeze sets permanent lock bit.
// R14 - Memory read gives dummy zero then 16-bit word MSB first.
// R15 - Data-out changes on serial clock rising edge.
// R16 - Held select streams next words with no dummy zero.
// R17 - Boundary write protects at and above address, flag to zero.
// R18 - Boundary clear sets all ones and flag to one.
// R19 - Data-out zero while programming, one after until start or deselect.
// R20 - Zeros before start bit are ignored.
module sec_decoder
    import sec_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter bit ADDR_MSB_IGNORE = 1'b0,
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic SEL_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    input wire logic WEN_PIN_I,
    input wire logic PROT_EN_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    output logic BUSY_O
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PC_W = $clog2(PROG_CNT + 1);
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_W - 1);
    localparam logic [CNT_W-1:0] WORD_LAST = CNT_W'(WORD_W - 1);
    localparam logic [CNT_W-1:0] OPC_LAST = CNT_W'(OPC_W - 1);
    localparam logic [CNT_W-1:0] GRD_BITS = CNT_W'(ADDR_W + 1);
    localparam logic [2:0] PAGE_MAX = 3'(PAGE_WORDS);
    localparam logic [ADDR_W-1:0] ADDR_ONES = '1;
    localparam logic [ADDR_W-1:0] ADDR_MASK =
        ADDR_MSB_IGNORE ? (ADDR_ONES >> 1) : ADDR_ONES;

    sec_pins_t pins_s1_r, pins_s2_r, pins_s3_r;
    sec_state_t state_r;
    sec_cmd_t cmd_r;
    logic [CNT_W-1:0] bit_cnt_r, out_left_r;
    logic [1:0] opc_r;
    logic [ADDR_W-1:0] addr_r, bound_r, fetch_addr_r;
    logic [WORD_W-1:0] data_sr_r, out_sr_r;
    logic [WORD_W-1:0] page_buf_r [PAGE_WORDS];
    logic [2:0] word_cnt_r;
    logic arm_r, w_ok_r, wen_r, unlock_r, flag_r, otp_r;
    logic status_r, sdo_r, fetch_act_r;
    logic [PC_W-1:0] prog_cnt_r;
    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] fifo_mem_r [2];
    logic fifo_wp_r, fifo_rp_r;
    logic [1:0] fifo_cnt_r;

    // Synchronised pin view; stage one feeds only stage two
    wire clk_rise = pins_s2_r.sclk & ~pins_s3_r.sclk; // R8
    wire sel_rise = pins_s2_r.sel & ~pins_s3_r.sel;
    wire sel_fall = ~pins_s2_r.sel & pins_s3_r.sel;
    wire sdi = pins_s2_r.sdi;
    wire busy = prog_cnt_r != '0;
    wire [ADDR_W-1:0] addr_full = {addr_r[ADDR_W-2:0], sdi};
    wire [ADDR_W-1:0] addr_eff = addr_full & ADDR_MASK; // R7
    wire [1:0] ext = addr_full[ADDR_W-1 -: 2]; // R5
    wire addr_zero = addr_full == '0;
    wire addr_ones = addr_full == ADDR_ONES;
    wire w_now = w_ok_r & pins_s2_r.wen;
    wire prot_pin = pins_s2_r.prot;
    wire last_addr = clk_rise & (state_r == ST_ADDR)
        & (bit_cnt_r == ADDR_LAST);
    wire word_done = clk_rise & (state_r == ST_DATA)
        & (bit_cnt_r == WORD_LAST);
    wire [WORD_W-1:0] word_full = {data_sr_r[WORD_W-2:0], sdi};

    // Decode of the completed instruction at the last address bit
    wire dec_read = last_addr & (opc_r == OPC_READ) & ~prot_pin; // R14
    wire dec_grd = last_addr & (opc_r == OPC_READ) & prot_pin; // R12
    wire dec_write = last_addr & (opc_r == OPC_WRITE) & ~prot_pin; // R9
    wire dec_page = last_addr & (opc_r == OPC_PAGE) & ~prot_pin; // R10
    wire dec_ext = last_addr & (opc_r == OPC_EXT);
    wire dec_fill = dec_ext & (ext == EXT_FILL) & ~prot_pin; // R11
    wire dec_wen = dec_ext & (ext == EXT_UNLOCK) & ~prot_pin & w_now;
    wire dec_wds = dec_ext & (ext == EXT_LOCK) & ~prot_pin; // R11
    wire dec_unlock = dec_ext & (ext == EXT_UNLOCK) & prot_pin & w_now
        & wen_r; // R11
    wire guard_ok = prot_pin & w_now & unlock_r & ~otp_r;
    wire dec_bset = last_addr & (opc_r == OPC_WRITE) & guard_ok; // R17
    wire dec_bclr = last_addr & (opc_r == OPC_PAGE) & addr_ones
        & guard_ok; // R18
    wire dec_freeze = dec_ext & addr_zero & guard_ok; // R13
    wire dec_data = dec_write | dec_page | dec_fill;

    // Protection check for the single word and every loaded page word
    logic page_prot;
    logic [ADDR_W-1:0] pg_addr;
    always_comb begin
        page_prot = 1'b0;
        pg_addr = addr_r;
        for (int i = 0; i < PAGE_WORDS; i++) begin
            pg_addr = {addr_r[ADDR_W-1:2], addr_r[1:0] + 2'(i)};
            if (3'(i) < word_cnt_r && !flag_r && pg_addr >= bound_r) begin
                page_prot = 1'b1; // R10
            end
        end
    end
    wire word_prot = !flag_r && (addr_r >= bound_r); // R9

    // Commit only when select falls right after a whole word
    wire commit = sel_fall & arm_r & w_now & wen_r & ~busy
        & ((state_r == ST_DATA) | (state_r == ST_DONE));
    wire do_write = commit & (cmd_r == CMD_WRITE) & ~word_prot; // R9
    wire do_page = commit & (cmd_r == CMD_PAGE) & ~page_prot; // R10
    wire do_fill = commit & (cmd_r == CMD_FILL) & flag_r; // R11
    wire prog_start = do_write | do_page | do_fill;

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pins_s1_r <= PINS_RST;
            pins_s2_r <= PINS_RST;
            pins_s3_r <= PINS_RST;
        end else begin
            pins_s1_r <= '{SEL_I, SCLK_I, SDI_I, WEN_PIN_I, PROT_EN_I};
            pins_s2_r <= pins_s1_r;
            pins_s3_r <= pins_s2_r;
        end
    end

    // Instruction framing
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_r <= ST_IDLE; // R1
            bit_cnt_r <= '0;
            opc_r <= '0;
            addr_r <= '0;
            data_sr_r <= '0;
            word_cnt_r <= '0;
            arm_r <= 1'b0;
            w_ok_r <= 1'b0;
            cmd_r <= CMD_WRITE;
        end else if (!pins_s2_r.sel) begin
            state_r <= ST_IDLE;
            arm_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // Stays put while busy; data on the bus is ignored
                    if (!busy && (sel_rise ? !pins_s2_r.sclk : status_r)) begin
                        state_r <= ST_START; // R3
                    end
                end
                ST_START: begin
                    if (clk_rise && sdi) begin // R4 R20
                        state_r <= ST_OPC;
                        bit_cnt_r <= '0;
                        w_ok_r <= pins_s2_r.wen;
                    end
                end
                ST_OPC: begin
                    if (clk_rise) begin
                        opc_r <= {opc_r[0], sdi}; // R5
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        if (bit_cnt_r == OPC_LAST) begin
                            state_r <= ST_ADDR;
                            bit_cnt_r <= '0;
                        end
                    end
                end
                ST_ADDR: begin
                    if (clk_rise) begin
                        addr_r <= addr_full; // R6
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                    if (last_addr) begin
                        addr_r <= addr_eff;
                        bit_cnt_r <= '0;
                        word_cnt_r <= '0;
                        state_r <= dec_read ? ST_READ :
                                   dec_grd ? ST_GRD :
                                   dec_data ? ST_DATA : ST_DONE;
                        cmd_r <= dec_page ? CMD_PAGE :
                                 dec_fill ? CMD_FILL : CMD_WRITE;
                    end
                end
                ST_DATA: begin
                    if (clk_rise) begin
                        data_sr_r <= word_full;
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        arm_r <= 1'b0;
                    end
                    if (word_done) begin
                        page_buf_r[word_cnt_r[1:0]] <= word_full;
                        word_cnt_r <= word_cnt_r + 1'b1;
                        bit_cnt_r <= '0;
                        arm_r <= 1'b1;
                        if (cmd_r != CMD_PAGE ||
                            word_cnt_r + 1'b1 == PAGE_MAX) begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_READ, ST_GRD: state_r <= state_r;
                ST_DONE: begin
                    // One clock too many after the data disarms the write
                    if (clk_rise) begin
                        arm_r <= 1'b0;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            if (clk_rise && !pins_s2_r.wen) begin
                w_ok_r <= 1'b0;
            end
        end
    end

    // Write enable, protection boundary, flag and lock bit
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wen_r <= WEN_RST; // R1
            unlock_r <= 1'b0;
            bound_r <= ADDR_ONES;
            flag_r <= FLAG_RST;
            otp_r <= OTP_RST;
        end else if (last_addr) begin
            unlock_r <= dec_unlock; // R11
            if (dec_wen) begin
                wen_r <= 1'b1; // R11
            end else if (dec_wds) begin
                wen_r <= 1'b0; // R11
            end
            if (dec_bclr) begin
                bound_r <= ADDR_ONES; // R18
                flag_r <= 1'b1; // R18
            end else if (dec_bset) begin
                bound_r <= addr_eff; // R17
                flag_r <= 1'b0; // R17
            end
            if (dec_freeze) begin
                otp_r <= 1'b1; // R13
            end
        end
    end

    // Self-timed programming and ready/busy indication
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            prog_cnt_r <= '0; // R1
            status_r <= 1'b0;
        end else begin
            if (prog_start) begin
                prog_cnt_r <= PC_W'(PROG_CNT);
                status_r <= 1'b1;
            end else if (busy) begin
                prog_cnt_r <= prog_cnt_r - 1'b1;
            end
            if (!busy && !prog_start && (state_r == ST_START) &&
                (!pins_s2_r.sel || (clk_rise && sdi))) begin
                status_r <= 1'b0; // R19
            end else if (!busy && !prog_start && sel_fall) begin
                // No programming starts on this edge; deselect ends the ready status
                status_r <= 1'b0; // R19
            end
        end
    end

    // Array writes; memory content has no reset, like the cells it models
    always_ff @(posedge CORE_CLK_I) begin
        if (do_write) begin
            mem_r[addr_r] <= page_buf_r[0]; // R9
        end
        for (int i = 0; i < PAGE_WORDS; i++) begin
            if (do_page && 3'(i) < word_cnt_r) begin
                mem_r[{addr_r[ADDR_W-1:2], addr_r[1:0] + 2'(i)}]
                    <= page_buf_r[i]; // R10
            end
        end
        for (int j = 0; j < DEPTH; j++) begin
            if (do_fill) begin
                mem_r[j] <= page_buf_r[0]; // R11
            end
        end
    end

    // Two-entry read buffer: fetcher fills, output shifter drains
    wire push_rdy = fifo_cnt_r != FIFO_DEPTH;
    wire push = fetch_act_r & push_rdy;
    wire pop_vld = fifo_cnt_r != '0;
    wire word_edge = clk_rise & (state_r == ST_READ) & (out_left_r == '0);
    wire pop = word_edge & pop_vld;
    wire [WORD_W-1:0] pop_data = fifo_mem_r[fifo_rp_r];

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fetch_act_r <= 1'b0;
            fetch_addr_r <= '0;
            fifo_wp_r <= 1'b0;
            fifo_rp_r <= 1'b0;
            fifo_cnt_r <= '0;
            fifo_mem_r <= '{default: '0};
        end else if (dec_read) begin
            fetch_act_r <= 1'b1;
            fetch_addr_r <= addr_eff;
            fifo_wp_r <= 1'b0;
            fifo_rp_r <= 1'b0;
            fifo_cnt_r <= '0;
        end else begin
            fetch_act_r <= fetch_act_r & (state_r == ST_READ);
            if (push) begin
                fifo_mem_r[fifo_wp_r] <= mem_r[fetch_addr_r];
                fifo_wp_r <= ~fifo_wp_r;
                fetch_addr_r <= (fetch_addr_r + 1'b1) & ADDR_MASK; // R16
            end
            if (pop) begin
                fifo_rp_r <= ~fifo_rp_r;
            end
            fifo_cnt_r <= fifo_cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Serial output shifter
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sdo_r <= 1'b0;
            out_sr_r <= '0;
            out_left_r <= '0;
        end else if (!pins_s2_r.sel) begin
            sdo_r <= 1'b0;
        end else if (status_r) begin
            sdo_r <= busy ? BUSY_BIT : READY_BIT; // R19
        end else if (dec_read || dec_grd) begin
            sdo_r <= DUMMY_BIT; // R14
            out_left_r <= dec_grd ? GRD_BITS : '0;
            out_sr_r <= '0;
            out_sr_r[WORD_W-1 -: ADDR_W+1] <= {bound_r, flag_r}; // R12
        end else if (word_edge) begin
            // No dummy between words while select is held
            sdo_r <= pop_data[WORD_W-1]; // R15 R16
            out_sr_r <= {pop_data[WORD_W-2:0], 1'b0};
            out_left_r <= WORD_LAST;
        end else if (clk_rise && state_r inside {ST_READ, ST_GRD}) begin
            sdo_r <= (out_left_r != '0) ? out_sr_r[WORD_W-1] : 1'b0; // R15
            out_sr_r <= {out_sr_r[WORD_W-2:0], 1'b0};
            if (out_left_r != '0) begin
                out_left_r <= out_left_r - 1'b1;
            end
        end
    end

    assign SDO_O = sdo_r;
    assign SDO_OE_O = pins_s2_r.sel;
    assign BUSY_O = busy;
endmodule

// *** sec_decoder_bench.sv ***
`timescale 1ns/1ps
module sec_decoder_bench
    import sec_pkg::*;
;
    localparam int PROG = 20;
    localparam int LIMIT = 40000;
    logic clk, rst_n, sel, sclk, sdi, wen, prot, sdo, sdo_oe, busy;
    logic [31:0] q;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    sec_decoder #(.PROG_CNT(PROG)) dut (.CORE_CLK_I(clk),
        .RESETN_I(rst_n), .SEL_I(sel), .SCLK_I(sclk), .SDI_I(sdi),
        .WEN_PIN_I(wen), .PROT_EN_I(prot), .SDO_O(sdo),
        .SDO_OE_O(sdo_oe), .BUSY_O(busy));
    sec_host_model host (.clk_i(clk), .sdo_i(sdo), .sel_o(sel),
        .sclk_o(sclk), .sdi_o(sdi), .wen_o(wen), .prot_o(prot));

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic inst(input logic w, input logic p, input int n,
        input logic [31:0] v);
        host.pins(w, p);
        host.select();
        host.shift(n, v, q);
        host.deselect();
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        inst(1'b1, 1'b0, 27, {5'h0, 1'b1, OPC_WRITE, a, d});
    endtask

    task automatic ctl(input logic p, input logic [1:0] op,
        input logic [7:0] a);
        inst(1'b1, p, 11, {21'h0, 1'b1, op, a});
    endtask

    // Leaves the device selected so a caller may keep streaming
    task automatic rd(input logic p, input logic [7:0] a);
        logic dm;
        host.pins(1'b0, p);
        host.select();
        host.shift(11, {21'h0, 1'b1, OPC_READ, a}, q);
        dm = q[0];
        host.shift(16, 32'h0, q);
        q[16] = dm;
    endtask

    task automatic page(input logic [7:0] a, input int n);
        host.pins(1'b1, 1'b0);
        host.select();
        host.shift(11, {21'h0, 1'b1, OPC_PAGE, a}, q);
        for (int i = 0; i < n; i++) begin
            host.shift(16, {16'h0, 16'hC0D0 + 16'(i)}, q);
        end
        host.deselect();
    endtask

    task automatic prog_wait(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (PROG + 10) begin
            @(negedge clk);
            seen = seen | (busy === 1'b1);
        end
        check("busy", {31'h0, exp}, {31'h0, seen});
    endtask

    task automatic t_por();
        check("sdo", 32'h0, {31'h0, sdo});
        wr(8'h05, 16'hA5C3);
        prog_wait(1'b0);
        $display("test por done");
    endtask

    task automatic t_write();
        inst(1'b1, 1'b0, 14, {22'h1, OPC_EXT, EXT_UNLOCK, 6'h00});
        host.pins(1'b1, 1'b0);
        host.select();
        host.shift(27, {5'h0, 1'b1, OPC_WRITE, 8'h05, 16'hA5C3}, q);
        host.deselect();
        host.select();
        check("busy level", 32'h0, {31'h0, sdo});
        repeat (PROG + 10) @(negedge clk);
        check("ready level", 32'h1, {31'h0, sdo});
        host.deselect();
        rd(1'b0, 8'h05);
        check("read word", 32'hA5C3, q);
        host.deselect();
        $display("test write done");
    endtask

    task automatic t_page();
        page(8'h12, 4);
        prog_wait(1'b1);
        rd(1'b0, 8'h10);
        check("wrapped word", 32'hC0D2, q);
        // Serial clock stopped between words; state must hold
        repeat (200) @(negedge clk);
        check("held sdo", 32'h0, {31'h0, sdo});
        host.shift(16, 32'h0, q);
        check("streamed word", 32'hC0D3, q);
        host.deselect();
        $display("test page done");
    endtask

    task automatic t_guard();
        ctl(1'b1, OPC_EXT, {EXT_UNLOCK, 6'h00});
        ctl(1'b1, OPC_WRITE, 8'h22);
        rd(1'b1, 8'h00);
        check("bound set", 32'h2200, q);
        host.deselect();
        page(8'h20, 3);
        prog_wait(1'b0);
        wr(8'h21, 16'h1234);
        prog_wait(1'b1);
        wr(8'h22, 16'h1234);
        prog_wait(1'b0);
        $display("test guard done");
    endtask

    task automatic t_clear();
        ctl(1'b1, OPC_EXT, {EXT_UNLOCK, 6'h00});
        ctl(1'b1, OPC_PAGE, 8'hFF);
        rd(1'b1, 8'h00);
        check("bound clear", 32'hFF80, q);
        host.deselect();
        inst(1'b1, 1'b0, 27, {5'h0, 1'b1, OPC_EXT, EXT_FILL, 22'h5A5A});
        prog_wait(1'b1);
        rd(1'b0, 8'h33);
        check("fill word", 32'h5A5A, q);
        host.deselect();
        $display("test clear done");
    endtask

    task automatic t_lock();
        inst(1'b0, 1'b0, 11, {22'h1, OPC_EXT, EXT_LOCK, 6'h00});
        wr(8'h05, 16'h0000);
        prog_wait(1'b0);
        ctl(1'b0, OPC_EXT, {EXT_UNLOCK, 6'h00});
        ctl(1'b1, OPC_EXT, {EXT_UNLOCK, 6'h00});
        ctl(1'b1, OPC_EXT, 8'h00);
        ctl(1'b1, OPC_EXT, {EXT_UNLOCK, 6'h00});
        ctl(1'b1, OPC_WRITE, 8'h40);
        rd(1'b1, 8'h00);
        check("frozen bound", 32'hFF80, q);
        host.deselect();
        $display("test lock done");
    endtask

    initial begin
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_por();
        t_write();
        t_page();
        t_guard();
        t_clear();
        t_lock();
        finish_test();
    end
endmodule

bind sec_decoder sec_decoder_props #(.PROG_CNT(PROG_CNT)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .SEL_I(SEL_I),
    .SCLK_I(SCLK_I), .SDI_I(SDI_I), .WEN_PIN_I(WEN_PIN_I),
    .PROT_EN_I(PROT_EN_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O),
    .BUSY_O(BUSY_O));

// *** sec_decoder_properties.sv ***
`timescale 1ns/1ps
module sec_decoder_props
    import sec_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    input wire logic SEL_I,
    input wire logic SCLK_I,
    input wire logic SDI_I,
    input wire logic WEN_PIN_I,
    input wire logic PROT_EN_I,
    input wire logic SDO_O,
    input wire logic SDO_OE_O,
    input wire logic BUSY_O
);
    logic sclk_d_r;
    logic [3:0] age_r;
    logic [19:0] busy_cnt_r;

    // Age saturates so a stopped serial clock never wraps it
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sclk_d_r <= 1'b0;
            age_r <= 4'hF;
            busy_cnt_r <= 20'h0;
        end else begin
            sclk_d_r <= SCLK_I;
            age_r <= (SCLK_I && !sclk_d_r) ? 4'h0 :
                ((age_r == 4'hF) ? 4'hF : age_r + 4'h1);
            busy_cnt_r <= BUSY_O ? busy_cnt_r + 20'h1 : 20'h0;
        end
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    chk_reset_quiet: assert property (disable iff (1'b0)
        !RESETN_I |-> !SDO_O && !SDO_OE_O && !BUSY_O)
        else $error("outputs active during reset");
    chk_oe_on_select: assert property (
        $rose(SEL_I) |-> ##[1:3] SDO_OE_O)
        else $error("output enable late after select");
    chk_oe_off_desel: assert property (
        $fell(SEL_I) |-> ##[1:3] !SDO_OE_O)
        else $error("output enable stuck after deselect");
    chk_quiet_unsel: assert property (
        !SDO_OE_O && !$past(SDO_OE_O) |-> !SDO_O)
        else $error("data out high while deselected");
    chk_sdo_on_rise: assert property (
        $changed(SDO_O) && SDO_OE_O && $past(SDO_OE_O, 2) && !BUSY_O
        && !$past(BUSY_O, 2) && !$past(BUSY_O, 3)
        |-> age_r inside {[4'h1:4'h6]})
        else $error("data out moved without a clock rise");
    chk_busy_length: assert property (
        $fell(BUSY_O) |-> busy_cnt_r == PROG_CNT)
        else $error("programming time wrong");
    chk_busy_cause: assert property (
        $rose(BUSY_O) |-> !SEL_I && WEN_PIN_I && !PROT_EN_I)
        else $error("programming started without its conditions");
    chk_busy_zero: assert property (
        BUSY_O && $past(BUSY_O) && SDO_OE_O |-> !SDO_O)
        else $error("data out not zero while busy");
    chk_ready_one: assert property (
        $fell(BUSY_O) && SDO_OE_O |-> ##[0:2] SDO_O)
        else $error("ready level missing");

    cov_prog: cover property ($fell(BUSY_O));
    cov_ready: cover property ($fell(BUSY_O) && SDO_OE_O);
    cov_read: cover property (SDO_OE_O && $rose(SDO_O) && !BUSY_O);
endmodule

// *** sec_host_model.sv ***
`timescale 1ns/1ps
module sec_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sel_o,
    output logic sclk_o,
    output logic sdi_o,
    output logic wen_o,
    output logic prot_o
);
    initial begin
        sel_o = 1'b0;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        wen_o = 1'b0;
        prot_o = 1'b0;
    end

    task automatic pins(input logic w, input logic p);
        @(negedge clk_i);
        wen_o = w;
        prot_o = p;
    endtask

    // Serial clock is always low here, so each select opens a frame
    task automatic select();
        @(negedge clk_i);
        sel_o = 1'b1;
        repeat (5) @(negedge clk_i);
    endtask

    // Released data line shows the inverse, never the last bit
    task automatic deselect();
        @(negedge clk_i);
        sel_o = 1'b0;
        sdi_o = ~sdi_o;
        repeat (6) @(negedge clk_i);
    endtask

    // Data set up 3 clocks before rise; reply sampled before next rise
    task automatic shift(input int n, input logic [31:0] v,
        output logic [31:0] q);
        q = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = v[i];
            repeat (3) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (5) @(negedge clk_i);
            sclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
            q = {q[30:0], sdo_i};
        end
    endtask
endmodule

// *** sec_pkg.sv ***
package sec_pkg;
    // Core clock and self-timed programming time
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 10_000_000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

    localparam int WORD_W = 16;
    localparam int PAGE_WORDS = 4;
    localparam int OPC_W = 2;
    localparam int CNT_W = 5;
    localparam int ADDR_W_DEF = 8;

    // Opcodes and extension codes (top two address bits)
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_PAGE = 2'h3;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_FILL = 2'h1;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    // Reset values and fixed output levels
    localparam logic FLAG_RST = 1'h1;
    localparam logic OTP_RST = 1'h0;
    localparam logic WEN_RST = 1'h0;
    localparam logic DUMMY_BIT = 1'h0;
    localparam logic BUSY_BIT = 1'h0;
    localparam logic READY_BIT = 1'h1;
    localparam logic [1:0] LOW2_STEP = 2'h1;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef struct packed {
        logic sel;
        logic sclk;
        logic sdi;
        logic wen;
        logic prot;
    } sec_pins_t;

    localparam sec_pins_t PINS_RST = '0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_OPC,
        ST_ADDR,
        ST_DATA,
        ST_READ,
        ST_GRD,
        ST_DONE
    } sec_state_t;

    typedef enum logic [1:0] {
        CMD_WRITE,
        CMD_PAGE,
        CMD_FILL
    } sec_cmd_t;
endpackage
